// File: pkg/gw_pkg.sv
// Shared constants and types for the dual GPIO port block with pin wake-up.
// Assumes a single 50 MHz clock domain and an Avalon-MM register master.
package gw_pkg;

	// Register byte addresses on the Avalon-MM slave, one aligned word each.
	localparam logic [7:0] OFS_A_DATA = 8'h00;
	localparam logic [7:0] OFS_A_DIR = 8'h04;
	localparam logic [7:0] OFS_A_PULL = 8'h08;
	localparam logic [7:0] OFS_A_WAKE = 8'h0C;
	localparam logic [7:0] OFS_B_DATA = 8'h10;
	localparam logic [7:0] OFS_B_DIR = 8'h14;
	localparam logic [7:0] OFS_B_PULL = 8'h18;
	localparam logic [7:0] OFS_FUNC = 8'h1C;
	localparam logic [7:0] OFS_BITOP = 8'h20;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h28;

	// Values after reset.
	localparam logic [7:0] RST_A_DATA = 8'hFF;
	localparam logic [7:0] RST_A_DIR = 8'hFF;
	localparam logic [6:0] RST_A_PULL = 7'h00;
	localparam logic [7:0] RST_A_WAKE = 8'h00;
	localparam logic [1:0] RST_B_DATA = 2'h3;
	localparam logic [1:0] RST_B_DIR = 2'h3;
	localparam logic [1:0] RST_B_PULL = 2'h0;
	localparam logic [7:0] RST_IRQ_MASK = 8'h00;

	// Field positions.
	localparam int FUNC_FDIV_BIT = 0;
	localparam int FUNC_PWM_BIT = 1;
	localparam int FUNC_AN_LSB = 2;
	localparam int BITOP_IDX_LSB = 0;
	localparam int BITOP_VAL_BIT = 3;
	localparam int BITOP_PORT_BIT = 4;

	// First-port pins that carry shared functions.
	localparam int FDIV_PIN = 5;
	localparam int PWM_PIN = 4;
	localparam int EXT_IRQ_PIN = 3;

	// Avalon-MM request from the master.
	typedef struct packed {
		logic read;
		logic write;
		logic [7:0] address;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} gw_avs_req_t;

	// Complete state of the port block.
	typedef struct packed {
		logic [7:0] a_data;
		logic [7:0] a_dir;
		logic [6:0] a_pull;
		logic [7:0] a_wake;
		logic [1:0] b_data;
		logic [1:0] b_dir;
		logic [1:0] b_pull;
		logic fdiv_sel;
		logic pwm_sel;
		logic [1:0] an_sel;
		logic [7:0] stat;
		logic [7:0] mask;
		logic [7:0] a_prev;
		logic ack;
		logic wake;
		logic [31:0] rdata;
	} gw_state_t;

endpackage

// File: design/gw_sync.sv
// Two-stage synchroniser for a vector of pad inputs.
// Assumes the inputs are asynchronous to clk_i; only the second stage is read outside.
`timescale 1ns/1ps
`default_nettype none
module gw_sync #(
	parameter int W = 8
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} gw_sync_state_t;

	gw_sync_state_t st_q;
	gw_sync_state_t st_d;

	// The first stage feeds only the second one.
	always_comb begin
		st_d = st_q;
		st_d.s1 = d_i;
		st_d.s2 = st_q.s1;
	end

	// Pads idle high through their pull-ups, so both stages start high.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_q <= '1;
		end else begin
			st_q <= st_d;
		end
	end

	assign q_o = st_q.s2;
endmodule
`default_nettype wire

// File: design/gw_pad.sv
// Pad control for a group of bidirectional pins: drive, enable and weak pull-up.
// Assumes all inputs come from registers on the same clock.
`timescale 1ns/1ps
`default_nettype none
module gw_pad #(
	parameter int W = 8
) (
	input wire logic [W-1:0] dir_i,
	input wire logic [W-1:0] latch_i,
	input wire logic [W-1:0] alt_en_i,
	input wire logic [W-1:0] alt_val_i,
	input wire logic [W-1:0] pull_en_i,
	input wire logic [W-1:0] analog_i,
	output logic [W-1:0] out_o,
	output logic [W-1:0] oe_o,
	output logic [W-1:0] pull_o
);
	// A shared function only reaches a pin set as output; an input pin stays a plain input.
	assign oe_o = ~dir_i;
	assign out_o = (alt_en_i & alt_val_i) | (~alt_en_i & latch_i);
	// The pull-up is cut for output pins and for pins claimed as analog inputs.
	assign pull_o = pull_en_i & dir_i & ~analog_i;
endmodule
`default_nettype wire

// File: design/gw_port.sv
// Dual GPIO port with per-pin direction, output latch and pull-up (none on first-port pin 7), and falling-edge wake on first-port pins only.
// Assumes an Avalon-MM master on clk_i, pads outside that resolve out, oe and pull.
//
// Local design decisions: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module gw_port (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire gw_pkg::gw_avs_req_t avs_req_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic [7:0] first_port_in_i,
	output logic [7:0] first_port_out_o,
	output logic [7:0] first_port_oe_o,
	output logic [7:0] first_port_pull_o,
	input wire logic [1:0] second_port_in_i,
	output logic [1:0] second_port_out_o,
	output logic [1:0] second_port_oe_o,
	output logic [1:0] second_port_pull_o,
	input wire logic freq_divider_out_i,
	input wire logic pwm_out_i,
	input wire logic sleep_i,
	output logic wake_o,
	output logic irq_o,
	output logic [7:0] first_port_level_o,
	output logic [1:0] second_port_level_o,
	output logic [1:0] analog_pin_select_o
);
	gw_pkg::gw_state_t st_q;
	gw_pkg::gw_state_t st_d;
	logic [7:0] a_sync;
	logic [1:0] b_sync;
	logic [7:0] a_rd;
	logic [1:0] b_rd;
	logic [7:0] addr;
	logic req_any;
	logic take;
	logic commit_wr;
	logic [31:0] rd_val;
	logic [7:0] fall_ev;
	logic [7:0] a_alt_en;
	logic [7:0] a_alt_val;

	// Pads are asynchronous, so every pin level passes two flops first.
	gw_sync #(
		.W(8)
	) u_sync_a (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.d_i(first_port_in_i),
		.q_o(a_sync)
	);

	gw_sync #(
		.W(2)
	) u_sync_b (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.d_i(second_port_in_i),
		.q_o(b_sync)
	);

	// Bus handshake: the request is sampled in its first cycle, answered in the second.
	assign addr = {avs_req_i.address[7:2], 2'h0};
	assign req_any = avs_req_i.read | avs_req_i.write;
	assign take = req_any & ~st_q.ack;
	assign commit_wr = st_q.ack & avs_req_i.write & avs_req_i.byteenable[0];
	assign avs_waitrequest_o = take;

	// Input pins show the pad, output pins show the latch; a bit operation copies input pad levels into the latch.
	assign a_rd = (st_q.a_dir & a_sync) | (~st_q.a_dir & st_q.a_data);
	assign b_rd = (st_q.b_dir & b_sync) | (~st_q.b_dir & st_q.b_data);

	// Falling edges on wake-enabled first-port pins.
	assign fall_ev = st_q.a_prev & ~a_sync & st_q.a_wake;

	// Shared functions on the first port.
	assign a_alt_en = ({7'h00, st_q.fdiv_sel} << gw_pkg::FDIV_PIN)
		| ({7'h00, st_q.pwm_sel} << gw_pkg::PWM_PIN);
	assign a_alt_val = ({7'h00, freq_divider_out_i} << gw_pkg::FDIV_PIN)
		| ({7'h00, pwm_out_i} << gw_pkg::PWM_PIN);

	// Read multiplexer; unused bits and unmapped addresses read as zero.
	always_comb begin
		rd_val = 32'h0000_0000;
		case (addr)
			gw_pkg::OFS_A_DATA: begin
				rd_val[7:0] = a_rd;
			end
			gw_pkg::OFS_A_DIR: begin
				rd_val[7:0] = st_q.a_dir;
			end
			gw_pkg::OFS_A_PULL: begin
				rd_val[6:0] = st_q.a_pull;
			end
			gw_pkg::OFS_A_WAKE: begin
				rd_val[7:0] = st_q.a_wake;
			end
			gw_pkg::OFS_B_DATA: begin
				rd_val[1:0] = b_rd;
			end
			gw_pkg::OFS_B_DIR: begin
				rd_val[1:0] = st_q.b_dir;
			end
			gw_pkg::OFS_B_PULL: begin
				rd_val[1:0] = st_q.b_pull;
			end
			gw_pkg::OFS_FUNC: begin
				rd_val[gw_pkg::FUNC_FDIV_BIT] = st_q.fdiv_sel;
				rd_val[gw_pkg::FUNC_PWM_BIT] = st_q.pwm_sel;
				rd_val[gw_pkg::FUNC_AN_LSB +: 2] = st_q.an_sel;
			end
			gw_pkg::OFS_IRQ_STAT: begin
				rd_val[7:0] = st_q.stat;
			end
			gw_pkg::OFS_IRQ_MASK: begin
				rd_val[7:0] = st_q.mask;
			end
			default: begin
				rd_val = 32'h0000_0000;
			end
		endcase
	end

	// Next state: register writes at the answering edge, events every cycle.
	always_comb begin
		logic [7:0] a_mod;
		logic [1:0] b_mod;
		logic [2:0] idx;
		logic bval;
		a_mod = a_rd;
		b_mod = b_rd;
		idx = avs_req_i.writedata[gw_pkg::BITOP_IDX_LSB +: 3];
		bval = avs_req_i.writedata[gw_pkg::BITOP_VAL_BIT];
		st_d = st_q;
		st_d.ack = take;
		st_d.wake = 1'b0;
		st_d.a_prev = a_sync;
		if (take & avs_req_i.read) begin
			st_d.rdata = rd_val;
		end
		if (commit_wr) begin
			case (addr)
				gw_pkg::OFS_A_DATA: begin
					st_d.a_data = avs_req_i.writedata[7:0];
				end
				gw_pkg::OFS_A_DIR: begin
					st_d.a_dir = avs_req_i.writedata[7:0];
				end
				gw_pkg::OFS_A_PULL: begin
					st_d.a_pull = avs_req_i.writedata[6:0];
				end
				gw_pkg::OFS_A_WAKE: begin
					st_d.a_wake = avs_req_i.writedata[7:0];
				end
				gw_pkg::OFS_B_DATA: begin
					st_d.b_data = avs_req_i.writedata[1:0];
				end
				gw_pkg::OFS_B_DIR: begin
					st_d.b_dir = avs_req_i.writedata[1:0];
				end
				gw_pkg::OFS_B_PULL: begin
					st_d.b_pull = avs_req_i.writedata[1:0];
				end
				gw_pkg::OFS_FUNC: begin
					st_d.fdiv_sel = avs_req_i.writedata[gw_pkg::FUNC_FDIV_BIT];
					st_d.pwm_sel = avs_req_i.writedata[gw_pkg::FUNC_PWM_BIT];
					st_d.an_sel = avs_req_i.writedata[gw_pkg::FUNC_AN_LSB +: 2];
				end
				gw_pkg::OFS_BITOP: begin
					// The whole port is read back, so input pins copy their pad level.
					if (avs_req_i.writedata[gw_pkg::BITOP_PORT_BIT]) begin
						b_mod[idx[0]] = bval;
						st_d.b_data = b_mod;
					end else begin
						a_mod[idx] = bval;
						st_d.a_data = a_mod;
					end
				end
				gw_pkg::OFS_IRQ_MASK: begin
					st_d.mask = avs_req_i.writedata[7:0];
				end
				default: begin
					st_d.ack = take;
				end
			endcase
		end
		// Only bits that the read returned are cleared; a new edge sets again and wins.
		if (st_q.ack & avs_req_i.read & (addr == gw_pkg::OFS_IRQ_STAT)) begin
			st_d.stat = st_q.stat & ~st_q.rdata[7:0];
		end
		st_d.stat = st_d.stat | fall_ev;
		if (sleep_i & (|fall_ev)) begin
			st_d.wake = 1'b1;
		end
	end

	// State register with documented reset values.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_q <= '0;
			st_q.a_data <= gw_pkg::RST_A_DATA;
			st_q.a_dir <= gw_pkg::RST_A_DIR;
			st_q.a_pull <= gw_pkg::RST_A_PULL;
			st_q.a_wake <= gw_pkg::RST_A_WAKE;
			st_q.b_data <= gw_pkg::RST_B_DATA;
			st_q.b_dir <= gw_pkg::RST_B_DIR;
			st_q.b_pull <= gw_pkg::RST_B_PULL;
			st_q.mask <= gw_pkg::RST_IRQ_MASK;
			st_q.a_prev <= 8'hFF;
		end else begin
			st_q <= st_d;
		end
	end

	// First-port pads; pin 7 has no pull-up control.
	gw_pad #(
		.W(8)
	) u_pad_a (
		.dir_i(st_q.a_dir),
		.latch_i(st_q.a_data),
		.alt_en_i(a_alt_en),
		.alt_val_i(a_alt_val),
		.pull_en_i({1'b0, st_q.a_pull}),
		.analog_i(8'h00),
		.out_o(first_port_out_o),
		.oe_o(first_port_oe_o),
		.pull_o(first_port_pull_o)
	);

	// Second-port pads; analog claims remove the pull-up.
	gw_pad #(
		.W(2)
	) u_pad_b (
		.dir_i(st_q.b_dir),
		.latch_i(st_q.b_data),
		.alt_en_i(2'h0),
		.alt_val_i(2'h0),
		.pull_en_i(st_q.b_pull),
		.analog_i(st_q.an_sel),
		.out_o(second_port_out_o),
		.oe_o(second_port_oe_o),
		.pull_o(second_port_pull_o)
	);

	// Outputs. Shared-function levels go to the interrupt and counter logic outside.
	assign avs_readdata_o = st_q.rdata;
	assign wake_o = st_q.wake;
	assign irq_o = |(st_q.stat & st_q.mask);
	assign first_port_level_o = a_sync;
	assign second_port_level_o = b_sync;
	assign analog_pin_select_o = st_q.an_sel;

	chk_wait_bound: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		req_any |-> ##[0:1] !avs_waitrequest_o)
		else $error("request not answered within one wait cycle");

	chk_dir_write_oe: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(commit_wr && addr == gw_pkg::OFS_A_DIR)
		|=> first_port_oe_o == ~$past(avs_req_i.writedata[7:0]))
		else $error("first-port enables do not follow written direction");

	chk_latch_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!(commit_wr && (addr == gw_pkg::OFS_A_DATA || addr == gw_pkg::OFS_BITOP))
		|=> $stable(st_q.a_data))
		else $error("first-port latch changed without a write");

	chk_pull_gate: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(first_port_pull_o & ~(st_q.a_dir & {1'b0, st_q.a_pull})) == 8'h00)
		else $error("pull-up asserted on output or unenabled pin");

	chk_analog_pull: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(second_port_pull_o & st_q.an_sel) == 2'h0)
		else $error("pull-up left on an analog pin");

	chk_wake_event: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(sleep_i && |(st_q.a_prev & ~a_sync & st_q.a_wake)) |=> wake_o)
		else $error("enabled falling edge during sleep gave no wake");

	chk_wake_cause: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		wake_o |-> $past(sleep_i) && ($past(st_q.a_wake) != 8'h00))
		else $error("wake without sleep or without an enabled pin");

	chk_read_latch: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(st_q.ack && avs_req_i.read && addr == gw_pkg::OFS_A_DATA && $stable(st_q.a_dir))
		|-> ((avs_readdata_o[7:0] ^ st_q.a_data) & ~st_q.a_dir) == 8'h00)
		else $error("output pin read did not return the latch");

	chk_pull_reserved: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(st_q.ack && avs_req_i.read && addr == gw_pkg::OFS_A_PULL)
		|-> avs_readdata_o[31:7] == 25'h0000000)
		else $error("unimplemented pull bits read nonzero");

	chk_bitop_rmw: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(commit_wr && addr == gw_pkg::OFS_BITOP && !avs_req_i.writedata[4])
		|=> st_q.a_data[$past(avs_req_i.writedata[2:0])] == $past(avs_req_i.writedata[3]))
		else $error("bit operation did not set the addressed latch bit");

	chk_b_bitop: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(commit_wr && addr == gw_pkg::OFS_BITOP && avs_req_i.writedata[gw_pkg::BITOP_PORT_BIT])
		|=> st_q.b_data[$past(avs_req_i.writedata[0])]
		== $past(avs_req_i.writedata[gw_pkg::BITOP_VAL_BIT]))
		else $error("bit operation did not set the addressed second-port latch bit");

	chk_stat_set: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(|fall_ev) |=> ((st_q.stat & $past(fall_ev)) == $past(fall_ev)))
		else $error("enabled falling edge did not set its status bit");

	chk_b_dir_oe: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(commit_wr && addr == gw_pkg::OFS_B_DIR)
		|=> second_port_oe_o == ~$past(avs_req_i.writedata[1:0]))
		else $error("second-port enables do not follow written direction");

	chk_out_latch: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(!st_q.fdiv_sel && !st_q.pwm_sel) |-> first_port_out_o == st_q.a_data)
		else $error("first-port drive differs from the latch");

	chk_fdiv_route: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(st_q.fdiv_sel && !st_q.a_dir[gw_pkg::FDIV_PIN])
		|-> first_port_oe_o[gw_pkg::FDIV_PIN]
		&& first_port_out_o[gw_pkg::FDIV_PIN] == freq_divider_out_i)
		else $error("divider output missing on its output pin");

	chk_pwm_input: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(st_q.pwm_sel && st_q.a_dir[gw_pkg::PWM_PIN]) |-> !first_port_oe_o[gw_pkg::PWM_PIN])
		else $error("pwm output drives a pin set as input");
endmodule
`default_nettype wire

// File: testbench/gw_board.sv
// Board model for one group of pads: switches, pull-ups and lines left floating.
// Assumes the pad controls come from the port block on the same clock.
`timescale 1ns/1ps
`default_nettype none
module gw_board #(
	parameter int W = 8
) (
	input wire logic clk_i,
	input wire logic [W-1:0] out_i,
	input wire logic [W-1:0] oe_i,
	input wire logic [W-1:0] pull_i,
	input wire logic [W-1:0] ext_en_i,
	input wire logic [W-1:0] ext_val_i,
	input wire logic [W-1:0] short_i,
	output logic [W-1:0] pin_o
);
	logic [W-1:0] float_q = '0;

	// An undriven line wanders every cycle, so a stale level is never read back.
	always @(posedge clk_i) begin
		float_q <= ~float_q;
	end

	// A short overrides the pad drive only when a scenario asks for one.
	always_comb begin
		for (int i = 0; i < W; i++) begin
			if (short_i[i]) pin_o[i] = ext_val_i[i];
			else if (oe_i[i]) pin_o[i] = out_i[i];
			else if (ext_en_i[i]) pin_o[i] = ext_val_i[i];
			else if (pull_i[i]) pin_o[i] = 1'b1;
			else pin_o[i] = float_q[i];
		end
	end
endmodule
`default_nettype wire

// File: testbench/gw_port_bench.sv
// Self-checking bench for the dual GPIO port block, driven over its Avalon-MM slave.
// Assumes the board model resolves pad levels from the block's drive controls.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module gw_port_bench;
	logic clk_i = 1'b0;
	logic rst_b_i;
	gw_pkg::gw_avs_req_t req;
	logic [31:0] rdata, q;
	logic wait_r, wake, irq, fdiv, pwm, sleep;
	logic [7:0] a_out, a_oe, a_pull, a_pin, a_en, a_val, a_short, a_lvl;
	logic [1:0] b_out, b_oe, b_pull, b_pin, b_val, an_sel, b_lvl, b_short;
	int mismatches = 0;
	int comparisons = 0;
	int wake_n = 0;

	gw_port dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .avs_req_i(req), .avs_readdata_o(rdata),
		.avs_waitrequest_o(wait_r), .first_port_in_i(a_pin), .first_port_out_o(a_out),
		.first_port_oe_o(a_oe), .first_port_pull_o(a_pull), .second_port_in_i(b_pin),
		.second_port_out_o(b_out), .second_port_oe_o(b_oe), .second_port_pull_o(b_pull),
		.freq_divider_out_i(fdiv), .pwm_out_i(pwm), .sleep_i(sleep), .wake_o(wake),
		.irq_o(irq), .first_port_level_o(a_lvl), .second_port_level_o(b_lvl),
		.analog_pin_select_o(an_sel));
	gw_board #(.W(8)) brd_a (.clk_i(clk_i), .out_i(a_out), .oe_i(a_oe), .pull_i(a_pull),
		.ext_en_i(a_en), .ext_val_i(a_val), .short_i(a_short), .pin_o(a_pin));
	gw_board #(.W(2)) brd_b (.clk_i(clk_i), .out_i(b_out), .oe_i(b_oe), .pull_i(b_pull),
		.ext_en_i(2'h3), .ext_val_i(b_val), .short_i(b_short), .pin_o(b_pin));

	// Half-period toggle gives the 50 MHz clock.
	always #10 clk_i = ~clk_i;

	// Wake pulses are counted so a missing or doubled pulse shows.
	always @(posedge clk_i) begin
		if (wake === 1'b1) wake_n++;
	end

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// One Avalon transfer: hold until waitrequest is seen low, take data at that edge.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		req.read <= ~wr;
		req.write <= wr;
		req.address <= a;
		req.writedata <= d;
		req.byteenable <= 4'hF;
		do begin
			@(posedge clk_i);
			n++;
		end while (wait_r !== 1'b0 && n < 50);
		q = rdata;
		req.read <= 1'b0;
		req.write <= 1'b0;
		if (n >= 50) begin
			mismatches++;
			$display("[FAIL] %0t bus answer missing", $time);
			print_verdict();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0);
	endtask

	// Waits until the pad levels have passed the input synchroniser.
	task automatic pads(input logic [7:0] v, input logic [7:0] s);
		@(posedge clk_i);
		a_val <= v;
		a_short <= s;
		repeat (5) @(posedge clk_i);
	endtask

	// Watchdog cuts a hang short.
	initial begin
		repeat (3000) @(posedge clk_i);
		mismatches++;
		print_verdict();
	end

	initial begin
		logic [7:0] ofs [9];
		logic [31:0] exp_v [9];
		ofs = '{gw_pkg::OFS_A_DIR, gw_pkg::OFS_A_WAKE, gw_pkg::OFS_A_PULL, gw_pkg::OFS_B_DIR,
			gw_pkg::OFS_B_PULL, gw_pkg::OFS_IRQ_MASK, gw_pkg::OFS_A_DATA, 8'h3C,
			gw_pkg::OFS_B_DATA};
		exp_v = '{32'hFF, 32'h0, 32'h0, 32'h3, 32'h0, 32'h0, 32'hA5, 32'h0, 32'h2};
		req = '0;
		rst_b_i = 1'b0;
		a_en = 8'hFF;
		a_val = 8'hA5;
		a_short = 8'h00;
		b_val = 2'h2;
		b_short = 2'h0;
		fdiv = 1'b1;
		pwm = 1'b0;
		sleep = 1'b0;
		repeat (5) @(posedge clk_i);
		rst_b_i <= 1'b1;
		// Reset values, live pad read on inputs, unmapped address reads zero.
		for (int i = 0; i < 9; i++) begin
			rd(ofs[i]);
			`CHK(q, exp_v[i])
		end
		// Input levels reach the interrupt and counter logic outside.
		`CHK(a_lvl, 8'hA5)
		`CHK(b_lvl, 2'h2)
		`CHK(a_oe, 8'h00)
		`CHK(a_out, 8'hFF)
		`CHK(b_out, 2'h3)
		// Only implemented bits stick; the rest read back as zero.
		wr(gw_pkg::OFS_A_PULL, 32'hFF);
		rd(gw_pkg::OFS_A_PULL);
		`CHK(q, 32'h7F)
		wr(gw_pkg::OFS_B_DIR, 32'hFF);
		rd(gw_pkg::OFS_B_DIR);
		`CHK(q, 32'h3)
		wr(gw_pkg::OFS_B_PULL, 32'hFF);
		rd(gw_pkg::OFS_B_PULL);
		`CHK(q, 32'h3)
		`CHK(a_pull, 8'h7F)
		// Upper nibble as outputs, shorted on the board to the opposite level.
		wr(gw_pkg::OFS_A_DATA, 32'h5A);
		wr(gw_pkg::OFS_A_DIR, 32'h0F);
		@(negedge clk_i);
		`CHK(a_oe, 8'hF0)
		`CHK(a_out[7:4], 4'h5)
		`CHK(a_pull, 8'h0F)
		pads(8'hA5, 8'hF0);
		rd(gw_pkg::OFS_A_DATA);
		`CHK(q, 32'h55)
		pads(8'h3C, 8'h00);
		`CHK(a_out[7:4], 4'h5)
		rd(gw_pkg::OFS_A_DATA);
		`CHK(q, 32'h5C)
		// Bit clear then bit set write the whole read-back port into the latch.
		wr(gw_pkg::OFS_BITOP, 32'h02);
		wr(gw_pkg::OFS_BITOP, 32'h08);
		wr(gw_pkg::OFS_A_DIR, 32'h00);
		@(negedge clk_i);
		`CHK(a_out, 8'h5D)
		// Divider and PWM reach their pins only as outputs.
		wr(gw_pkg::OFS_FUNC, 32'h3);
		@(negedge clk_i);
		`CHK(a_out[5:4], 2'b10)
		wr(gw_pkg::OFS_A_DIR, 32'h30);
		@(negedge clk_i);
		`CHK(a_oe[5:4], 2'b00)
		`CHK(a_pull[5:4], 2'b11)
		// Analog claim drops the second-port pull-up.
		wr(gw_pkg::OFS_FUNC, 32'h4);
		@(negedge clk_i);
		`CHK(an_sel, 2'b01)
		`CHK(b_pull, 2'b10)
		wr(gw_pkg::OFS_FUNC, 32'hC);
		@(negedge clk_i);
		`CHK(b_pull, 2'b00)
		wr(gw_pkg::OFS_B_DATA, 32'h1);
		wr(gw_pkg::OFS_B_DIR, 32'h0);
		@(negedge clk_i);
		`CHK(b_oe, 2'h3)
		`CHK(b_out, 2'h1)
		// Shorted second-port outputs still read back the latch; a bit set rewrites it.
		@(posedge clk_i);
		b_short <= 2'h3;
		repeat (3) @(posedge clk_i);
		rd(gw_pkg::OFS_B_DATA);
		`CHK(q, 32'h1)
		wr(gw_pkg::OFS_BITOP, 32'h19);
		@(negedge clk_i);
		`CHK(b_out, 2'h3)
		// Wake on pin 2 only; pin 3, used as the interrupt input, has wake off.
		wr(gw_pkg::OFS_A_DIR, 32'hFF);
		wr(gw_pkg::OFS_A_WAKE, 32'h04);
		wr(gw_pkg::OFS_IRQ_MASK, 32'h04);
		pads(8'hFF, 8'h00);
		rd(gw_pkg::OFS_IRQ_STAT);
		sleep <= 1'b1;
		pads(8'hF7, 8'h00);
		`CHK(wake_n, 0)
		pads(8'hF3, 8'h00);
		repeat (3) @(posedge clk_i);
		`CHK(wake_n, 1)
		`CHK(irq, 1'b1)
		rd(gw_pkg::OFS_IRQ_STAT);
		`CHK(q, 32'h04)
		@(negedge clk_i);
		`CHK(irq, 1'b0)
		// Awake, an edge sets status but gives no pulse; a masked bit keeps irq low.
		wr(gw_pkg::OFS_IRQ_MASK, 32'h00);
		sleep <= 1'b0;
		pads(8'hFF, 8'h00);
		pads(8'hFB, 8'h00);
		`CHK(wake_n, 1)
		`CHK(irq, 1'b0)
		rd(gw_pkg::OFS_IRQ_STAT);
		`CHK(q, 32'h04)
		print_verdict();
	end
endmodule
`default_nettype wire
